/* shared/fwr_pkg.sv */
// Register map, field layout and state encoding of the fault recorder
package fwr_pkg;
	localparam logic [7:0] FWR_REG_CTRL = 8'h00;
	localparam logic [7:0] FWR_REG_CHAN = 8'h04;
	localparam logic [7:0] FWR_REG_CYC = 8'h08;
	localparam logic [7:0] FWR_REG_TRIG = 8'h0C;
	localparam logic [7:0] FWR_REG_APPLY = 8'h10;
	localparam logic [7:0] FWR_REG_STATUS = 8'h14;
	localparam logic [7:0] FWR_REG_SIZE = 8'h18;
	localparam logic [7:0] FWR_REG_CAP = 8'h1C;
	localparam logic [7:0] FWR_REG_MADDR = 8'h20;
	localparam logic [7:0] FWR_REG_MDATA = 8'h24;
	localparam logic [7:0] FWR_REG_LAST = 8'h28;
	localparam logic [7:0] FWR_REG_OLDEST = 8'h2C;
	localparam int FWR_CTRL_RUN = 0;
	localparam int FWR_CTRL_CONT = 1;
	localparam int FWR_CTRL_WCI = 2;
	localparam int FWR_CYC_W = 8;
	localparam int FWR_CYC_POST_LSB = 8;
	localparam int FWR_ST_FULL_BIT = 3;
	localparam int FWR_ST_PREOK_BIT = 4;
	localparam int FWR_ST_STORED_LSB = 16;
	localparam int FWR_LAST_SLOT_LSB = 16;
	localparam logic [7:0] FWR_PRE_RST = 8'h01;
	localparam logic [7:0] FWR_POST_RST = 8'h01;
	localparam int FWR_MEM_UNITS = 6081;
	localparam int FWR_QUARTERS = 4;
	localparam int FWR_NCH = 7;
	localparam int FWR_NT = 24;
	localparam int FWR_W = 32;
	typedef enum logic [2:0] {
		FWR_ST_IDLE = 3'h0,
		FWR_ST_PRE = 3'h1,
		FWR_ST_POST = 3'h3,
		FWR_ST_FULL = 3'h2,
		FWR_ST_CFG = 3'h4
	} fwr_state_e;
endpackage

/* logic/fwr_pair_buf.sv */
// Two-entry valid/ready buffer between frame serializer and memory writer
`timescale 1ns/1ps
module fwr_pair_buf #(
	parameter int W = 32
)(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clear,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] slot_ff [2];
	logic wp_ff;
	logic rp_ff;
	logic [1:0] cnt_ff;
	logic push;
	logic pop;

	assign in_ready = (cnt_ff != 2'd2);
	assign out_valid = (cnt_ff != 2'd0);
	assign out_data = slot_ff[rp_ff];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
			slot_ff[wp_ff] <= in_data;
	end

	// Clear drops partial frames when accumulation stops
	always_ff @(posedge clk)
	begin
		if (!reset_n || clear)
		begin
			wp_ff <= 1'b0;
			rp_ff <= 1'b0;
			cnt_ff <= 2'd0;
		end
		else
		begin
			if (push)
				wp_ff <= ~wp_ff;
			if (pop)
				rp_ff <= ~rp_ff;
			cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

/* logic/fwr_recorder.sv */
// Trigger-driven waveform capture engine with fixed shared record memory
`timescale 1ns/1ps
module fwr_recorder
	import fwr_pkg::*;
#(
	parameter int NCH = FWR_NCH,
	parameter int NT = FWR_NT,
	parameter int W = FWR_W,
	parameter int MEM_UNITS = FWR_MEM_UNITS
)(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Capture sources
	input wire logic [NT-1:0] elem_operate,
	input wire logic capture_initiate_input,
	// Sample stream
	input wire logic cycle_tick,
	input wire logic quarter_tick,
	input wire logic [NCH*W-1:0] chan_data,
	input wire logic [W/FWR_QUARTERS-1:0] status_bits,
	// State
	output logic rec_busy,
	output logic rec_full
);
	localparam int AW = $clog2(MEM_UNITS + 1);
	localparam int CW = $clog2(NCH + 1);
	localparam int SB = W / FWR_QUARTERS;
	localparam int FW = FWR_CYC_W + 1;

	function automatic logic [CW-1:0] count_ones(input logic [NCH-1:0] v);
		logic [CW-1:0] n;
		n = '0;
		for (int i = 0; i < NCH; i++)
			n = n + CW'(v[i]);
		return n;
	endfunction

	fwr_state_e st_ff;
	logic run_ff, cont_ff, wci_en_ff;
	logic [NCH-1:0] chan_sel_ff;
	logic [FWR_CYC_W-1:0] pre_ff, post_ff;
	logic [NT-1:0] trig_en_ff, elem_prev_ff;
	logic wci_s1_ff, wci_s2_ff, wci_prev_ff;
	logic [AW-1:0] size_ff, rem_ff, cap_ff, stored_ff, slot_ff, oldest_ff;
	logic [AW-1:0] base_ff, wr_off_ff, mem_addr_ff;
	logic [CW-1:0] word_idx_ff, ser_idx_ff;
	logic [FW-1:0] cyc_idx_ff, fill_ff, post_left_ff, trig_pos_ff;
	logic [31:0] last_ff, rdata_ff;
	logic [W-1:0] mem_ff [MEM_UNITS];
	logic [W-1:0] dig_ff, dig_snap_ff;
	logic [NCH*W-1:0] snap_ff;
	logic ser_busy_ff;

	logic [CW-1:0] ch_cnt;
	logic [FW-1:0] cyc_last;
	logic [AW-1:0] size_calc, nxt_slot;
	logic acc, cfg_ok, apply, wci_rise, trig_any, pre_ok, trig_take;
	logic ser_emit, ser_adv, buf_in_valid, buf_in_ready;
	logic [W-1:0] buf_in_data, buf_out_data;
	logic buf_out_valid, buf_out_ready, wr_fire, frame_end, done_evt;
	logic mdata_rd;

	assign ch_cnt = count_ones(chan_sel_ff);
	assign cyc_last = FW'(pre_ff) + FW'(post_ff);
	assign size_calc = AW'((32'(ch_cnt) + 1) * (32'(cyc_last) + 1));
	assign acc = (st_ff == FWR_ST_PRE) || (st_ff == FWR_ST_POST);
	assign cfg_ok = (st_ff == FWR_ST_IDLE) || (st_ff == FWR_ST_FULL);
	assign apply = reg_wr && (reg_addr == FWR_REG_APPLY) && cfg_ok;
	assign mdata_rd = reg_rd && (reg_addr == FWR_REG_MDATA);
	assign rec_busy = (st_ff == FWR_ST_POST);
	assign rec_full = (st_ff == FWR_ST_FULL);
	assign reg_rdata = rdata_ff;

	// Settings other than the run bit only change while no capture is in progress
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			run_ff <= 1'b0;
			cont_ff <= 1'b0;
			wci_en_ff <= 1'b0;
			chan_sel_ff <= '1;
			pre_ff <= FWR_PRE_RST;
			post_ff <= FWR_POST_RST;
			trig_en_ff <= '0;
		end
		else if (apply)
			run_ff <= 1'b0;
		else if (reg_wr && reg_addr == FWR_REG_CTRL)
		begin
			run_ff <= reg_wdata[FWR_CTRL_RUN];
			if (cfg_ok)
			begin
				cont_ff <= reg_wdata[FWR_CTRL_CONT];
				wci_en_ff <= reg_wdata[FWR_CTRL_WCI];
			end
		end
		else if (reg_wr && cfg_ok)
		begin
			if (reg_addr == FWR_REG_CHAN)
				chan_sel_ff <= reg_wdata[NCH-1:0];
			if (reg_addr == FWR_REG_CYC)
			begin
				pre_ff <= reg_wdata[FWR_CYC_W-1:0];
				post_ff <= reg_wdata[FWR_CYC_POST_LSB +: FWR_CYC_W];
			end
			if (reg_addr == FWR_REG_TRIG)
				trig_en_ff <= reg_wdata[NT-1:0];
		end
	end

	// Contact input is asynchronous; element flags share this clock
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			wci_s1_ff <= 1'b0;
			wci_s2_ff <= 1'b0;
			wci_prev_ff <= 1'b0;
			elem_prev_ff <= '0;
		end
		else
		begin
			wci_s1_ff <= capture_initiate_input;
			wci_s2_ff <= wci_s1_ff;
			wci_prev_ff <= wci_s2_ff;
			elem_prev_ff <= elem_operate;
		end
	end

	assign wci_rise = wci_s2_ff && !wci_prev_ff && wci_en_ff;
	assign trig_any = |(elem_operate & ~elem_prev_ff & trig_en_ff) || wci_rise;
	assign pre_ok = (fill_ff >= FW'(pre_ff));
	assign trig_take = (st_ff == FWR_ST_PRE) && pre_ok && trig_any;

	// Capacity is found by repeated subtraction, no divider needed
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			size_ff <= '0;
			rem_ff <= '0;
			cap_ff <= '0;
		end
		else if (apply)
		begin
			size_ff <= size_calc;
			rem_ff <= AW'(MEM_UNITS);
			cap_ff <= '0;
		end
		else if (st_ff == FWR_ST_CFG && rem_ff >= size_ff)
		begin
			rem_ff <= rem_ff - size_ff;
			cap_ff <= cap_ff + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			st_ff <= FWR_ST_IDLE;
		else if (apply)
			st_ff <= FWR_ST_CFG;
		else
		begin
			case (st_ff)
				FWR_ST_CFG:
					if (rem_ff < size_ff)
						st_ff <= FWR_ST_IDLE;
				FWR_ST_IDLE:
					if (run_ff && cap_ff != '0)
						st_ff <= FWR_ST_PRE;
				FWR_ST_PRE:
					if (!run_ff)
						st_ff <= FWR_ST_IDLE;
					else if (trig_take)
						st_ff <= FWR_ST_POST;
				FWR_ST_POST:
					if (!run_ff)
						st_ff <= FWR_ST_IDLE;
					else if (done_evt)
						st_ff <= (!cont_ff && stored_ff + 1'b1 == cap_ff)
							? FWR_ST_FULL : FWR_ST_PRE;
				FWR_ST_FULL:
					st_ff <= FWR_ST_FULL;
				default:
					st_ff <= FWR_ST_IDLE;
			endcase
		end
	end

	// Four quarter-cycle status samples pack into one word
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			dig_ff <= '0;
		else if (quarter_tick)
			dig_ff <= {dig_ff[W-SB-1:0], status_bits};
	end

	// Serializer: digital word first, then each selected channel
	assign ser_emit = (ser_idx_ff == '0) || chan_sel_ff[ser_idx_ff - 1'b1];
	assign buf_in_valid = ser_busy_ff && ser_emit;
	assign ser_adv = ser_busy_ff && (!ser_emit || buf_in_ready);
	assign buf_in_data = (ser_idx_ff == '0) ? dig_snap_ff
		: snap_ff[(32'(ser_idx_ff) - 1) * W +: W];

	// A tick that lands while a frame is still draining is skipped whole
	always_ff @(posedge clk)
	begin
		if (!reset_n || !acc)
		begin
			ser_busy_ff <= 1'b0;
			ser_idx_ff <= '0;
		end
		else if (cycle_tick && !ser_busy_ff)
		begin
			ser_busy_ff <= 1'b1;
			ser_idx_ff <= '0;
		end
		else if (ser_adv)
		begin
			if (ser_idx_ff == CW'(NCH))
				ser_busy_ff <= 1'b0;
			ser_idx_ff <= ser_idx_ff + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (cycle_tick && !ser_busy_ff)
		begin
			snap_ff <= chan_data;
			dig_snap_ff <= dig_ff;
		end
	end

	fwr_pair_buf #(
		.W(W)
	) u_buf (
		.clk(clk),
		.reset_n(reset_n),
		.clear(!acc),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(buf_in_data),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_data(buf_out_data)
	);

	// Memory readout has priority; the writer stalls behind it
	assign buf_out_ready = !mdata_rd;
	assign wr_fire = buf_out_valid && buf_out_ready;
	assign frame_end = wr_fire && (word_idx_ff == ch_cnt);
	assign done_evt = (st_ff == FWR_ST_POST) && frame_end
		&& (post_left_ff == FW'(1));

	always_ff @(posedge clk)
	begin
		if (wr_fire)
			mem_ff[AW'(base_ff + wr_off_ff)] <= buf_out_data;
	end

	// Slot is circular until trigger plus post cycles close it
	always_ff @(posedge clk)
	begin
		if (!reset_n || !acc || done_evt)
		begin
			wr_off_ff <= '0;
			word_idx_ff <= '0;
			cyc_idx_ff <= '0;
		end
		else if (wr_fire)
		begin
			word_idx_ff <= frame_end ? '0 : word_idx_ff + 1'b1;
			if (frame_end && cyc_idx_ff == cyc_last)
			begin
				wr_off_ff <= '0;
				cyc_idx_ff <= '0;
			end
			else
			begin
				wr_off_ff <= wr_off_ff + 1'b1;
				if (frame_end)
					cyc_idx_ff <= cyc_idx_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n || !acc || done_evt)
			fill_ff <= '0;
		else if (frame_end && st_ff == FWR_ST_PRE && !pre_ok)
			fill_ff <= fill_ff + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			post_left_ff <= '0;
			trig_pos_ff <= '0;
		end
		else if (trig_take)
		begin
			post_left_ff <= FW'(post_ff) + 1'b1;
			trig_pos_ff <= cyc_idx_ff;
		end
		else if (frame_end && st_ff == FWR_ST_POST)
			post_left_ff <= post_left_ff - 1'b1;
	end

	assign nxt_slot = (slot_ff + 1'b1 == cap_ff) ? '0 : slot_ff + 1'b1;

	always_ff @(posedge clk)
	begin
		if (!reset_n || st_ff == FWR_ST_CFG)
		begin
			stored_ff <= '0;
			slot_ff <= '0;
			base_ff <= '0;
			oldest_ff <= '0;
			last_ff <= '0;
		end
		else if (done_evt)
		begin
			last_ff <= (32'(slot_ff) << FWR_LAST_SLOT_LSB) | 32'(trig_pos_ff);
			slot_ff <= cont_ff ? nxt_slot : slot_ff + 1'b1;
			base_ff <= (cont_ff && nxt_slot == '0) ? '0 : base_ff + size_ff;
			if (cont_ff && stored_ff == cap_ff - 1'b1)
				oldest_ff <= (oldest_ff + 1'b1 == cap_ff) ? '0
					: oldest_ff + 1'b1;
			else
				stored_ff <= stored_ff + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			mem_addr_ff <= '0;
		else if (reg_wr && reg_addr == FWR_REG_MADDR)
			mem_addr_ff <= reg_wdata[AW-1:0];
		else if (mdata_rd)
			mem_addr_ff <= mem_addr_ff + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n || !reg_rd)
			rdata_ff <= '0;
		else
		begin
			case (reg_addr)
				FWR_REG_CTRL:
					rdata_ff <= 32'({wci_en_ff, cont_ff, run_ff});
				FWR_REG_CHAN:
					rdata_ff <= 32'(chan_sel_ff);
				FWR_REG_CYC:
					rdata_ff <= 32'({post_ff, pre_ff});
				FWR_REG_TRIG:
					rdata_ff <= 32'(trig_en_ff);
				FWR_REG_STATUS:
					rdata_ff <= (32'(stored_ff) << FWR_ST_STORED_LSB)
						| (32'(pre_ok) << FWR_ST_PREOK_BIT)
						| (32'(rec_full) << FWR_ST_FULL_BIT) | 32'(st_ff);
				FWR_REG_SIZE:
					rdata_ff <= 32'(size_ff);
				FWR_REG_CAP:
					rdata_ff <= 32'(cap_ff);
				FWR_REG_MADDR:
					rdata_ff <= 32'(mem_addr_ff);
				FWR_REG_MDATA:
					rdata_ff <= (32'(mem_addr_ff) < MEM_UNITS)
						? 32'(mem_ff[mem_addr_ff]) : '0;
				FWR_REG_LAST:
					rdata_ff <= last_ff;
				FWR_REG_OLDEST:
					rdata_ff <= 32'(oldest_ff);
				default:
					rdata_ff <= '0;
			endcase
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	a_trig_needs_pre: assert property (
		trig_take |-> st_ff == FWR_ST_PRE && fill_ff >= FW'(pre_ff))
		else $error("trigger taken before pre-trigger fill");
	a_post_no_retrig: assert property (
		(st_ff == FWR_ST_POST && trig_any) |=> st_ff != FWR_ST_PRE
			|| $past(done_evt) || !$past(run_ff))
		else $error("trigger restarted an open record");
	a_trig_to_post: assert property (
		trig_take && run_ff && !apply |=> st_ff == FWR_ST_POST)
		else $error("trigger did not open a record");
	a_wci_edge: assert property (
		(wci_s2_ff && !wci_prev_ff && wci_en_ff && st_ff == FWR_ST_PRE
			&& pre_ok) |-> trig_take)
		else $error("contact edge not taken");
	a_full_holds: assert property (
		(st_ff == FWR_ST_FULL && !apply)[*3] |-> !trig_take && rec_full)
		else $error("full one-shot memory left full state");
	a_size_eq: assert property (
		st_ff == FWR_ST_CFG |-> size_ff == AW'((32'(ch_cnt) + 1)
			* (32'(pre_ff) + 32'(post_ff) + 1)))
		else $error("record size wrong");
	a_cap_quot: assert property (
		$fell(st_ff == FWR_ST_CFG) && st_ff == FWR_ST_IDLE
			|-> 32'(cap_ff) * 32'(size_ff) <= MEM_UNITS
			&& (32'(cap_ff) + 1) * 32'(size_ff) > MEM_UNITS)
		else $error("record capacity wrong");
	a_cont_keep: assert property (
		cont_ff && !rec_full && cap_ff != '0 |-> stored_ff < cap_ff)
		else $error("continuous mode stores too many records");
	a_oneshot_full: assert property (
		done_evt && !cont_ff && stored_ff + 1'b1 == cap_ff && run_ff
			&& !apply |=> st_ff == FWR_ST_FULL ##1 st_ff == FWR_ST_FULL)
		else $error("one-shot did not stop when full");
	a_quarter_sample: assert property (
		quarter_tick |=> dig_ff[SB-1:0] == $past(status_bits))
		else $error("status not sampled on quarter tick");
	a_oldest_move: assert property (
		done_evt && cont_ff && stored_ff == cap_ff - 1'b1 && cap_ff > 1
			|=> oldest_ff != $past(oldest_ff))
		else $error("oldest record not discarded");
	a_keep_records: assert property (
		st_ff != FWR_ST_CFG |=> stored_ff >= $past(stored_ff))
		else $error("stored records lost without reconfigure");

	c_capture: cover property (trig_take ##[1:1000] done_evt);
	c_full: cover property ($rose(st_ff == FWR_ST_FULL));
	c_wrap: cover property (done_evt && cont_ff
		&& stored_ff == cap_ff - 1'b1);
	c_stall: cover property (buf_out_valid && !buf_out_ready);
endmodule

/* verif/tb_fwr_recorder.sv */
// Self-checking testbench for the fault recorder capture engine
`timescale 1ns/1ps
module tb_fwr_recorder
	import fwr_pkg::*;
;
	// Small memory keeps record counts and run time short
	localparam int MEM = 240;
	localparam int NT = FWR_NT;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [31:0] reg_rdata;
	logic [NT-1:0] elem_operate = '0;
	logic capture_initiate_input = 1'h0;
	logic cycle_tick = 1'h0;
	logic quarter_tick = 1'h0;
	logic [FWR_NCH*FWR_W-1:0] chan_data = '0;
	logic [FWR_W/FWR_QUARTERS-1:0] status_bits = '0;
	logic rec_busy;
	logic rec_full;
	logic [3:0] tick_cnt = 4'h0;
	logic [31:0] rd_val;
	logic [6:0] sel;
	int num_errors = 0;
	int check_count = 0;
	int ch, pre, post, size, cap, tb_bit;

	always #12.5 clk = ~clk;

	// Frame every 16 cycles, well above the NCH+2 spacing limit
	always @(posedge clk)
	begin
		tick_cnt <= tick_cnt + 4'h1;
		cycle_tick <= (tick_cnt == 4'hF);
		quarter_tick <= (tick_cnt[1:0] == 2'h3);
	end

	fwr_recorder #(.MEM_UNITS(MEM)) u_fwr_recorder (
		.clk(clk),
		.reset_n(reset_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.elem_operate(elem_operate),
		.capture_initiate_input(capture_initiate_input),
		.cycle_tick(cycle_tick),
		.quarter_tick(quarter_tick),
		.chan_data(chan_data),
		.status_bits(status_bits),
		.rec_busy(rec_busy),
		.rec_full(rec_full)
	);

	task automatic summarize();
		$display("Checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, got);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		rd_val = reg_rdata;
	endtask

	task automatic wait_st(input logic [2:0] s, input bit need_pre);
		for (int i = 0; i < 400; i++)
		begin
			rd(FWR_REG_STATUS);
			if (rd_val[2:0] === s && (!need_pre ||
				rd_val[FWR_ST_PREOK_BIT] === 1'h1))
				break;
		end
	endtask

	task automatic wait_busy(input logic lvl, input int n);
		// Step off the edge so the state register has settled
		#1;
		for (int i = 0; i < n && rec_busy !== lvl; i++)
		begin
			@(posedge clk);
			#1;
		end
	endtask

	task automatic no_take(input int n, input string name);
		logic seen;
		seen = 1'h0;
		repeat (n)
		begin
			@(posedge clk);
			#1;
			seen = seen | rec_busy;
		end
		chk(name, 32'h0000_0000, {31'h0, seen});
	endtask

	function automatic logic [31:0] exp_word(input int i);
		int j, n;
		j = i % (1 + ch);
		n = 0;
		if (j == 0)
			return {4{status_bits}};
		for (int c = 0; c < FWR_NCH; c++)
		begin
			n += sel[c];
			if (sel[c] && n == j)
				return chan_data[c*FWR_W +: FWR_W];
		end
		return 32'h0000_0000;
	endfunction

	task automatic stored_is(input int exp);
		rd(FWR_REG_STATUS);
		chk("stored count", exp, {16'h0000, rd_val[31:16]});
	endtask

	task automatic apply();
		wr(FWR_REG_APPLY, 32'h0000_0000);
		wait_st(3'h0, 1'h0);
		stored_is(0);
		chk("full flag", 32'h0000_0000, {31'h0, rec_full});
	endtask

	task automatic cfg(input logic [6:0] s, input int p, q);
		sel = s;
		pre = p;
		post = q;
		ch = $countones(s);
		size = (1 + ch) * (1 + p + q);
		cap = MEM / size;
		tb_bit = $urandom_range(NT - 1);
		@(posedge clk);
		status_bits <= $urandom;
		for (int c = 0; c < FWR_NCH; c++)
			chan_data[c*FWR_W +: FWR_W] <= $urandom;
		wr(FWR_REG_CTRL, 32'h0000_0000);
		wr(FWR_REG_CHAN, {25'h0, s});
		wr(FWR_REG_CYC, {16'h0000, q[7:0], p[7:0]});
		wr(FWR_REG_TRIG, 32'h0000_0001 << tb_bit);
		apply();
		rd(FWR_REG_SIZE);
		chk("record size", size, rd_val);
		rd(FWR_REG_CAP);
		chk("capacity", cap, rd_val);
	endtask

	// One capture; a second edge arrives while the record is open
	task automatic fire(input bit contact, input int exp_stored);
		wait_st(3'h1, 1'h1);
		@(posedge clk);
		if (contact)
			capture_initiate_input <= 1'h1;
		else
			elem_operate[tb_bit] <= 1'h1;
		wait_busy(1'h1, 8);
		chk("capture start", 32'h1, {31'h0, rec_busy});
		repeat (2)
		begin
			@(posedge clk);
			elem_operate[tb_bit] <= ~elem_operate[tb_bit];
			@(posedge clk);
		end
		wait_busy(1'h0, 16 * (post + 4));
		stored_is(exp_stored);
		// Long enough for the pre-trigger frames to refill
		no_take(16 * (pre + 2), "held level retrigger");
		@(posedge clk);
		capture_initiate_input <= 1'h0;
		elem_operate <= '0;
	endtask

	task automatic slot_chk(input int k);
		wr(FWR_REG_MADDR, k * size);
		for (int i = 0; i < size; i++)
		begin
			rd(FWR_REG_MDATA);
			chk("record word", exp_word(i), rd_val);
		end
		rd(FWR_REG_MADDR);
		chk("memory address", (k + 1) * size, rd_val);
	endtask

	task automatic one_shot();
		wr(FWR_REG_CTRL, 32'h0000_0005);
		@(posedge clk);
		elem_operate[tb_bit] <= 1'h1;
		no_take(8, "early trigger");
		@(posedge clk);
		elem_operate <= '0;
		wait_st(3'h1, 1'h1);
		// Slot size must not change while a slot is being filled
		wr(FWR_REG_CHAN, 32'h0000_0000);
		rd(FWR_REG_CHAN);
		chk("locked channel select", {25'h0, sel}, rd_val);
		@(posedge clk);
		elem_operate[(tb_bit + 1) % NT] <= 1'h1;
		no_take(20, "disabled element");
		@(posedge clk);
		elem_operate <= '0;
		for (int i = 1; i <= cap; i++)
			fire(i[0], i);
		chk("full flag", 32'h1, {31'h0, rec_full});
		@(posedge clk);
		elem_operate[tb_bit] <= 1'h1;
		no_take(20, "trigger when full");
		@(posedge clk);
		elem_operate <= '0;
		stored_is(cap);
		slot_chk(0);
		slot_chk(cap - 1);
		rd(FWR_REG_LAST);
		chk("last slot", cap - 1, {16'h0000, rd_val[31:16]});
		$display("One-shot test done, %0d records", cap);
	endtask

	task automatic continuous();
		apply();
		wr(FWR_REG_CTRL, 32'h0000_0007);
		for (int i = 1; i <= cap + 1; i++)
			fire(i[0], (i < cap) ? i : cap - 1);
		rd(FWR_REG_OLDEST);
		chk("oldest slot", 2 % cap, rd_val);
		rd(FWR_REG_LAST);
		chk("last slot", 0, {16'h0000, rd_val[31:16]});
		wr(FWR_REG_CTRL, 32'h0000_0000);
		$display("Continuous test done, %0d records", cap);
	endtask

	initial
	begin
		// Largest random setup needs about 2000 cycles
		repeat (50000) @(posedge clk);
		num_errors++;
		$display("BAD watchdog expected finish seen hang");
		summarize();
	end

	initial
	begin
		void'($urandom(32'h7c0a));
		repeat (8) @(posedge clk);
		reset_n <= 1'h1;
		rd(FWR_REG_STATUS);
		chk("status reset", 32'h0000_0000, rd_val);
		rd(FWR_REG_CAP);
		chk("capacity reset", 32'h0000_0000, rd_val);
		rd(FWR_REG_CYC);
		chk("cycles reset", 32'h0000_0101, rd_val);
		rd(8'h30);
		chk("unmapped read", 32'h0000_0000, rd_val);
		$display("Reset test done");
		for (int t = 0; t < 2; t++)
		begin
			if (t == 0)
				cfg(7'h7F, 1, 2);
			else
				cfg($urandom_range(127, 1), $urandom_range(3, 1),
					$urandom_range(3, 1));
			one_shot();
			continuous();
		end
		summarize();
	end
endmodule
